// File: rtl/lec_pkg.sv
`default_nettype none
package lec_pkg;
  // Register map and layout
  localparam logic [7:0] REGULATOR_ENABLE_CONFIG_ADDR = 8'h39;
  localparam int RSVD_MSB = 7;
  localparam int RSVD_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int DISCHARGE_BIT = 3;
  localparam int ENABLE_MSB = 2;
  localparam int ENABLE_LSB = 0;
  localparam logic [2:0] RSVD_RESET = 3'h0;
  localparam int SLOT_COUNT = 4;
  // Enable-control codes
  localparam logic [2:0] ENABLE_FORCE_OFF_A = 3'h4;
  localparam logic [2:0] ENABLE_FORCE_OFF_B = 3'h5;
  localparam logic [2:0] ENABLE_FORCE_ON_A = 3'h6;
  localparam logic [2:0] ENABLE_FORCE_ON_B = 3'h7;
  typedef enum logic [2:0] {
    LEC_OUT_OFF = 3'b001,
    LEC_OUT_SEQ = 3'b010,
    LEC_OUT_ON = 3'b100
  } lec_out_state_t;
endpackage
`default_nettype wire

// File: rtl/lec_enable_decode.sv
`default_nettype none
// Turns the enable-control field and sequencer slots into an on request
module lec_enable_decode (
  input wire logic [2:0] enable_control_i,
  input wire logic [lec_pkg::SLOT_COUNT-1:0] slot_active_i,
  output var lec_pkg::lec_out_state_t mode_o,
  output logic output_on_o
);
  import lec_pkg::*;

  // Codes 0..3 follow a slot; 4,5 force off; 6,7 force on
  always_comb begin
    mode_o = LEC_OUT_SEQ;
    output_on_o = 1'b0;
    case (enable_control_i)
      ENABLE_FORCE_OFF_A, ENABLE_FORCE_OFF_B: begin
        mode_o = LEC_OUT_OFF;
        output_on_o = 1'b0;
      end
      ENABLE_FORCE_ON_A, ENABLE_FORCE_ON_B: begin
        mode_o = LEC_OUT_ON;
        output_on_o = 1'b1;
      end
      default: begin
        mode_o = LEC_OUT_SEQ;
        output_on_o = slot_active_i[enable_control_i[1:0]];
      end
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/lec_regulator_enable.sv
// Contract
// - Host writes zero to bits 7:5; their read value means nothing.
// - Bit 4 picks linear regulation (0) or load-switch operation (1).
// - Bit 3 set and output off switches in the discharge resistor.
// - Enable codes 4 and 5 hold the output off.
// - Enable codes 6 and 7 hold the output on.
`default_nettype none
module lec_regulator_enable #(
  parameter int SLOTS = lec_pkg::SLOT_COUNT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port, same clock domain
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Fuse defaults, sampled after reset release
  input wire logic otp_mode_i,
  input wire logic otp_discharge_i,
  input wire logic [2:0] otp_enable_i,
  // Sequencer slot levels, same clock domain
  input wire logic [lec_pkg::SLOT_COUNT-1:0] slot_active_i,
  // Analog controls
  output logic regulator_mode_select_o,
  output logic output_enable_o,
  output logic output_discharge_resistor_o
);
  import lec_pkg::*;

  // Stored register fields
  logic [2:0] rsvd_reg, rsvd_next;
  logic mode_reg, mode_next;
  logic dis_reg, dis_next;
  logic [2:0] en_reg, en_next;
  // Low until the fuse defaults have been copied in
  logic loaded_reg, loaded_next;
  // Registered analog controls
  logic on_reg, on_next;
  logic dis_out_reg, dis_out_next;
  // Registered read data
  logic [7:0] rdata_reg, rdata_next;
  // Decoder results and bus qualifiers
  logic dec_on;
  lec_out_state_t dec_mode;
  logic hit;
  logic wr_take;

  // Address match for the one register of this block
  assign hit = (reg_addr_i == REGULATOR_ENABLE_CONFIG_ADDR);
  // A write counts only once the fuse defaults are in; earlier it is lost
  assign wr_take = loaded_reg && reg_wr_i && hit;

  // Enable-code decode, shared with nothing else in the block
  lec_enable_decode u_decode (
    .enable_control_i(en_reg),
    .slot_active_i(slot_active_i[SLOT_COUNT-1:0]),
    .mode_o(dec_mode),
    .output_on_o(dec_on)
  );

  // Fuse-load flag: rises on the first clock after reset release
  always_comb begin
    loaded_next = 1'b1;
  end

  // Fuse-load flag register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= loaded_next;
    end
  end

  // Reserved bits: zero after reset, then kept as the host writes them
  always_comb begin
    rsvd_next = rsvd_reg;
    if (!loaded_reg) begin
      rsvd_next = RSVD_RESET;
    end else if (wr_take) begin
      // Not forced to zero; the host owns that, and reads return them as stored
      rsvd_next = reg_wdata_i[RSVD_MSB:RSVD_LSB];
    end
  end

  // Reserved bits register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsvd_reg <= RSVD_RESET;
    end else begin
      rsvd_reg <= rsvd_next;
    end
  end

  // Operating mode: fuse default first, then host writes
  always_comb begin
    mode_next = mode_reg;
    if (!loaded_reg) begin
      mode_next = otp_mode_i;
    end else if (wr_take) begin
      mode_next = reg_wdata_i[MODE_BIT];
    end
  end

  // Operating mode register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Discharge enable: fuse default first, then host writes
  always_comb begin
    dis_next = dis_reg;
    if (!loaded_reg) begin
      dis_next = otp_discharge_i;
    end else if (wr_take) begin
      dis_next = reg_wdata_i[DISCHARGE_BIT];
    end
  end

  // Discharge enable register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dis_reg <= 1'b0;
    end else begin
      dis_reg <= dis_next;
    end
  end

  // Enable control: fuse default first, then host writes
  always_comb begin
    en_next = en_reg;
    if (!loaded_reg) begin
      en_next = otp_enable_i;
    end else if (wr_take) begin
      en_next = reg_wdata_i[ENABLE_MSB:ENABLE_LSB];
    end
  end

  // Enable control register; held at a force-off code until fuses load
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_reg <= ENABLE_FORCE_OFF_A;
    end else begin
      en_reg <= en_next;
    end
  end

  // Enable and discharge controls trail the fields by one clock; the extra flop keeps
  // the pins free of decode glitches while a write lands
  always_comb begin
    on_next = 1'b0;
    dis_out_next = 1'b0;
    if (loaded_reg) begin
      case (dec_mode)
        LEC_OUT_OFF: begin
          on_next = 1'b0;
        end
        LEC_OUT_ON: begin
          on_next = 1'b1;
        end
        LEC_OUT_SEQ: begin
          on_next = dec_on;
        end
        default: begin
          on_next = 1'b0;
        end
      endcase
      // Discharge only while the output is off, forced off or with its slot low
      dis_out_next = dis_reg && !on_next;
    end
  end

  // Analog control registers; both off while in reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_reg <= 1'b0;
      dis_out_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      dis_out_reg <= dis_out_next;
    end
  end

  // Read data: field image one clock after the address, zero elsewhere
  always_comb begin
    rdata_next = 8'h00;
    if (hit) begin
      rdata_next = {rsvd_reg, mode_reg, dis_reg, en_reg};
    end
  end

  // Read data register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Ports straight from the flops
  assign reg_rdata_o = rdata_reg;
  assign regulator_mode_select_o = mode_reg;
  assign output_enable_o = on_reg;
  assign output_discharge_resistor_o = dis_out_reg;
endmodule
`default_nettype wire

// File: bench/lec_regulator_enable_monitor.sv
`default_nettype none
module lec_regulator_enable_monitor #(
  parameter int SLOTS = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic otp_mode_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [SLOTS-1:0] slot_active_i,
  input wire logic regulator_mode_select_o,
  input wire logic output_enable_o,
  input wire logic output_discharge_resistor_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Accepted write; the fuse-load edge ignores writes
  sequence s_wr;
    $past(rstn_i) && reg_wr_i &&
      reg_addr_i == lec_pkg::REGULATOR_ENABLE_CONFIG_ADDR;
  endsequence
  // Mode bit lands on the write edge
  a_mode_write: assert property (s_wr |=>
    regulator_mode_select_o == $past(reg_wdata_i[4]))
    else $error("mode bit does not follow the write");
  // Read data shows the mode bit one clock after the address
  a_mode_read: assert property (
    reg_addr_i == lec_pkg::REGULATOR_ENABLE_CONFIG_ADDR |=>
    reg_rdata_o[4] == $past(regulator_mode_select_o))
    else $error("read data mode bit wrong");
  // Discharge never while the output is on
  a_discharge_off: assert property (output_discharge_resistor_o |->
    !output_enable_o)
    else $error("discharge while output on");
  // Slot codes follow the chosen slot level
  a_slot_follow: assert property (s_wr ##0 !reg_wdata_i[2]
    ##1 !reg_wr_i ##1 $stable(slot_active_i) |-> output_enable_o ==
    slot_active_i[$past(reg_wdata_i[1:0], 2)])
    else $error("output does not follow its slot");
  // Force-off codes
  a_force_off: assert property (s_wr
    ##0 reg_wdata_i[2:1] == 2'b10 ##1 !reg_wr_i |=> !output_enable_o)
    else $error("forced off code left output on");
  // Force-on codes
  a_force_on: assert property (s_wr
    ##0 reg_wdata_i[2:1] == 2'b11 ##1 !reg_wr_i |=> output_enable_o)
    else $error("forced on code left output off");
  // Fuse mode default after every reset release
  a_fuse_load: assert property ($rose(rstn_i) |=>
    regulator_mode_select_o == $past(otp_mode_i))
    else $error("fuse mode default not loaded");
  c_write: cover property (s_wr);
  c_discharge: cover property (output_discharge_resistor_o);
  c_turn_on: cover property ($rose(output_enable_o));
endmodule
bind lec_regulator_enable lec_regulator_enable_monitor #(.SLOTS(SLOTS))
  u_mon (.clk_i, .rstn_i, .reg_wr_i, .otp_mode_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .slot_active_i, .regulator_mode_select_o,
  .output_enable_o, .output_discharge_resistor_o);
`default_nettype wire

// File: bench/lec_regulator_enable_bench.sv
`default_nettype none
module lec_regulator_enable_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rstn_i = 0, reg_wr_i = 0, md, en, ds, e;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rd_o;
  logic [3:0] slot_active_i = 4'h5;
  // Fuse defaults; changed across the mid-run reset
  logic otp_md = 1'b1, otp_ds = 1'b1;
  logic [2:0] otp_en = 3'h4;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  lec_regulator_enable u_dut (.clk_i, .rstn_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o(rd_o), .otp_mode_i(otp_md),
    .otp_discharge_i(otp_ds), .otp_enable_i(otp_en), .slot_active_i,
    .regulator_mode_select_o(md), .output_enable_o(en),
    .output_discharge_resistor_o(ds));
  task automatic chk(string n, logic [7:0] s, x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One write strobe, then one edge for the decoded outputs to land
  task automatic wr(logic [7:0] d);
    @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {9'h139, d};
    @(negedge clk_i) reg_wr_i = 0;
    @(negedge clk_i);
  endtask
  task automatic rd(logic [7:0] a, x);
    @(negedge clk_i) reg_addr_i = a;
    @(negedge clk_i) chk("rdata", rd_o, x);
  endtask
  // Hang guard, well above the ~50 cycles the run needs
  always @(posedge clk_i) if (++cyc == 200) begin
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1;
    repeat (2) @(negedge clk_i);
    chk("fuse", {md, ds, en}, 3'h6);
    rd(8'h39, 8'h1c);
    rd(8'h38, 8'h00);
    // Every enable code, with mode and discharge bits toggling too
    for (int c = 0; c < 8; c++) begin
      e = c[2] ? c[1] : slot_active_i[c[1:0]];
      wr({3'h0, c[0], ~c[0], c[2:0]});
      chk("mode", md, c[0]);
      chk("en", en, e);
      chk("dis", ds, !c[0] && !e);
    end
    rd(8'h39, 8'h17);
    // Mid-run reset with other fuses: linear, no discharge, forced on
    rstn_i = 0;
    {otp_md, otp_ds, otp_en} = 5'h06;
    @(negedge clk_i) chk("rst", {md, ds, en}, 3'h0);
    repeat (3) @(negedge clk_i);
    rstn_i = 1;
    repeat (2) @(negedge clk_i);
    chk("fuse2", {md, ds, en}, 3'h1);
    rd(8'h39, 8'h06);
    stop_test;
  end
endmodule
`default_nettype wire
